// file: dac_ctrl_cfg.svh
`ifndef DAC_CTRL_CFG_SVH
`define DAC_CTRL_CFG_SVH

// Serial frame layout
`define FRAME_BITS 16
`define FRAME_CNT_W 5
`define CH_HI 15
`define CH_LO 14
`define OP_HI 13
`define OP_LO 12
`define CODE_HI 11
`define CODE_W 12
`define NUM_CH 4

// Register offsets (byte addresses)
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_OUT_BASE 12'h008
`define REG_IN_BASE 12'h018
`define REG_LAST 12'h024

// Register fields
`define CTRL_SUPPLY_HIGH 0
`define ST_POWERED_DOWN 0
`define ST_WAKING 1
`define ST_LIVE 2
`define ST_TERM_LO 4
`define ST_GOOD_LO 16
`define ST_ABORT_LO 24
`define CTRL_RESET 1'h0

// Timing
`define CLK_NS 100
`define WAKE_3V_NS 800
`define WAKE_5V_NS 500
`define WAKE_3V_CYC (((`WAKE_3V_NS) / (`CLK_NS)) < 1 ? 1 : ((`WAKE_3V_NS) / (`CLK_NS)))
`define WAKE_5V_CYC (((`WAKE_5V_NS) / (`CLK_NS)) < 1 ? 1 : ((`WAKE_5V_NS) / (`CLK_NS)))

`endif

// file: dac_ctrl_pkg.sv
package dac_ctrl_pkg;

  // Receiver states, one-hot
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_SHIFT = 3'b010,
    RX_DONE  = 3'b100
  } rx_state_t;

  // Operation field meanings
  typedef enum logic [1:0] {
    OP_WRITE_ONLY   = 2'h0,
    OP_WRITE_UPDATE = 2'h1,
    OP_WRITE_ALL    = 2'h2,
    OP_POWER_DOWN   = 2'h3
  } op_t;

  // Output termination while powered down
  typedef enum logic [1:0] {
    TERM_NONE = 2'h0,
    TERM_HIZ  = 2'h1,
    TERM_2K5  = 2'h2,
    TERM_100K = 2'h3
  } term_t;

endpackage

// file: frame_if.sv
`timescale 1ns/10ps
// Completed or aborted frame from the serial receiver to the core
interface frame_if;
  logic frame_valid;
  logic frame_abort;
  logic [15:0] frame_word;

  modport rx (output frame_valid, output frame_abort, output frame_word);
  modport core (input frame_valid, input frame_abort, input frame_word);
endinterface

// file: serial_frame_rx.sv
`timescale 1ns/10ps
`include "dac_ctrl_cfg.svh"

module serial_frame_rx (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link pins, asynchronous to pclk
  input wire logic frame_sel_n,
  input wire logic shift_clk,
  input wire logic serial_data,
  // Frames to the core
  frame_if.rx frm
);

  logic [2:0] sel_sync, clk_sync, dat_sync;
  dac_ctrl_pkg::rx_state_t state, next_state;
  logic [`FRAME_BITS-1:0] shreg, next_shreg;
  logic [`FRAME_CNT_W-1:0] count, next_count;
  logic next_valid, next_abort;
  logic sel_n, fall, data_bit;

  // Two stages before use; the third sclk stage gives the previous level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_sync <= 3'h7;
      clk_sync <= 3'h0;
      dat_sync <= 3'h0;
    end else begin
      sel_sync <= {sel_sync[1:0], frame_sel_n};
      clk_sync <= {clk_sync[1:0], shift_clk};
      dat_sync <= {dat_sync[1:0], serial_data};
    end
  end

  assign sel_n = sel_sync[1];
  assign data_bit = dat_sync[1];
  assign fall = clk_sync[2] & ~clk_sync[1]; // Falling shift-clock edge

  // Shift MSB first on falling edges; abort on early select rise
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_count = count;
    next_valid = 1'b0;
    next_abort = 1'b0;
    case (state)
      dac_ctrl_pkg::RX_IDLE: begin
        next_count = '0;
        if (!sel_n) begin
          next_state = dac_ctrl_pkg::RX_SHIFT;
        end
      end
      dac_ctrl_pkg::RX_SHIFT: begin
        if (sel_n) begin
          next_state = dac_ctrl_pkg::RX_IDLE;
          next_abort = (count != '0);
        end else if (fall) begin
          next_shreg = {shreg[`FRAME_BITS-2:0], data_bit};
          next_count = count + 1'b1;
          if (count == `FRAME_CNT_W'(`FRAME_BITS - 1)) begin
            next_valid = 1'b1;
            next_state = dac_ctrl_pkg::RX_DONE;
          end
        end
      end
      dac_ctrl_pkg::RX_DONE: begin
        // Extra clocks and data ignored until select rises
        if (sel_n) begin
          next_state = dac_ctrl_pkg::RX_IDLE;
        end
      end
      default: next_state = dac_ctrl_pkg::RX_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= dac_ctrl_pkg::RX_IDLE;
      shreg <= '0;
      count <= '0;
      frm.frame_valid <= 1'b0;
      frm.frame_abort <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      count <= next_count;
      frm.frame_valid <= next_valid;
      frm.frame_abort <= next_abort;
    end
  end

  assign frm.frame_word = shreg;

endmodule // serial_frame_rx

// file: quad_dac_powerdown_control.sv
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "dac_ctrl_cfg.svh"
// Behaviour
// - At reset all four code registers are zero and outputs sit at zero.
// - Outputs stay at zero until the first complete valid frame arrives.
// - Operation field 11 powers down all four channels together.
// - In power-down, channel field 00 or 11 leaves the outputs high impedance.
// - In power-down, channel field 01 ties outputs to 2.5k, 10 to 100k, to ground.
// - Every power-down option disables bias, amplifiers and resistor strings.
// - Entering power-down leaves every code register unchanged.
// - On wake each channel keeps its old code unless the waking frame loads one.
// - Outputs start leaving power-down within the wake-up time of the waking frame.
// - Frames are 16 bits MSB first on falling edges: channel, operation, code.
// - The frame executes on the sixteenth falling edge; later edges are ignored.
// - Select rising before the sixteenth edge discards the frame; codes and outputs are unaffected.

module quad_dac_powerdown_control #(
  parameter int WAKE_W = 4
) (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link from the host
  input wire logic frame_sel_n,
  input wire logic shift_clk,
  input wire logic serial_data,
  // Analog control
  output logic [47:0] dac_codes,
  output logic linear_enable,
  output logic output_drive,
  output logic term_hiz,
  output logic term_2k5,
  output logic term_100k
);

  localparam int CW = `CODE_W;

  frame_if frm ();

  serial_frame_rx rx (
    .pclk(pclk),
    .presetn(presetn),
    .frame_sel_n(frame_sel_n),
    .shift_clk(shift_clk),
    .serial_data(serial_data),
    .frm(frm)
  );

  logic [47:0] in_codes, next_in_codes, next_dac_codes;
  logic powered_down, next_powered_down;
  logic live, next_live;
  logic waking, next_waking;
  logic [WAKE_W-1:0] wake_cnt, next_wake_cnt;
  dac_ctrl_pkg::term_t term, next_term;
  logic next_linear_enable, next_output_drive;
  logic next_term_hiz, next_term_2k5, next_term_100k;
  logic supply_high, next_supply_high;
  logic [7:0] good_cnt, next_good_cnt, abort_cnt, next_abort_cnt;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [1:0] ch;
  dac_ctrl_pkg::op_t op;
  logic [CW-1:0] code;

  // Channel field to termination
  function automatic dac_ctrl_pkg::term_t term_of(input logic [1:0] chf);
    if (chf == 2'h1) begin
      term_of = dac_ctrl_pkg::TERM_2K5;
    end else if (chf == 2'h2) begin
      term_of = dac_ctrl_pkg::TERM_100K;
    end else begin
      term_of = dac_ctrl_pkg::TERM_HIZ;
    end
  endfunction

  // Wake delay in cycles for the selected supply
  function automatic logic [WAKE_W-1:0] wake_len(input logic high);
    wake_len = high ? WAKE_W'(`WAKE_5V_CYC) : WAKE_W'(`WAKE_3V_CYC);
  endfunction

  // Register word to channel; both code banks start where address bits 3:2 read 2
  function automatic logic [1:0] chan_of(input logic [11:0] addr);
    chan_of = 2'(addr[3:2] - 2'h2);
  endfunction

  assign ch = frm.frame_word[`CH_HI:`CH_LO];
  assign op = dac_ctrl_pkg::op_t'(frm.frame_word[`OP_HI:`OP_LO]);
  assign code = frm.frame_word[`CODE_HI:0];

  // Frame execution and power state
  always_comb begin
    next_in_codes = in_codes;
    next_dac_codes = dac_codes;
    next_powered_down = powered_down;
    next_live = live;
    next_waking = waking;
    next_wake_cnt = wake_cnt;
    next_term = term;
    next_good_cnt = good_cnt;
    next_abort_cnt = abort_cnt;
    if (waking) begin
      // Amplifiers settle before they drive again
      if (wake_cnt <= WAKE_W'(1)) begin
        next_waking = 1'b0;
      end else begin
        next_wake_cnt = wake_cnt - WAKE_W'(1);
      end
    end
    if (frm.frame_abort) begin
      next_abort_cnt = abort_cnt + 8'h01;
    end
    if (frm.frame_valid) begin
      next_good_cnt = good_cnt + 8'h01;
      next_live = 1'b1;
      if (op == dac_ctrl_pkg::OP_POWER_DOWN) begin
        // Codes untouched so a wake restores them
        next_powered_down = 1'b1;
        next_waking = 1'b0;
        next_term = term_of(ch);
      end else begin
        if (powered_down) begin
          next_powered_down = 1'b0;
          next_waking = 1'b1;
          next_wake_cnt = wake_len(supply_high);
          next_term = dac_ctrl_pkg::TERM_NONE;
        end
        case (op)
          dac_ctrl_pkg::OP_WRITE_ONLY: begin
            next_in_codes[ch*CW +: CW] = code;
          end
          dac_ctrl_pkg::OP_WRITE_UPDATE: begin
            next_in_codes[ch*CW +: CW] = code;
            next_dac_codes = next_in_codes;
          end
          default: begin
            next_in_codes = {`NUM_CH{code}};
            next_dac_codes = {`NUM_CH{code}};
          end
        endcase
      end
    end
    next_linear_enable = !next_powered_down;
    next_output_drive = !next_powered_down && !next_waking;
    next_term_hiz = next_term == dac_ctrl_pkg::TERM_HIZ;
    next_term_2k5 = next_term == dac_ctrl_pkg::TERM_2K5;
    next_term_100k = next_term == dac_ctrl_pkg::TERM_100K;
  end

  // Power and code registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_codes <= '0;
      dac_codes <= '0;
      powered_down <= 1'b0;
      live <= 1'b0;
      waking <= 1'b0;
      wake_cnt <= '0;
      term <= dac_ctrl_pkg::TERM_NONE;
      good_cnt <= 8'h00;
      abort_cnt <= 8'h00;
      linear_enable <= 1'b1;
      output_drive <= 1'b1;
      term_hiz <= 1'b0;
      term_2k5 <= 1'b0;
      term_100k <= 1'b0;
    end else begin
      in_codes <= next_in_codes;
      dac_codes <= next_dac_codes;
      powered_down <= next_powered_down;
      live <= next_live;
      waking <= next_waking;
      wake_cnt <= next_wake_cnt;
      term <= next_term;
      good_cnt <= next_good_cnt;
      abort_cnt <= next_abort_cnt;
      linear_enable <= next_linear_enable;
      output_drive <= next_output_drive;
      term_hiz <= next_term_hiz;
      term_2k5 <= next_term_2k5;
      term_100k <= next_term_100k;
    end
  end

  // APB: one wait state, answer registered so every output is a flop
  always_comb begin
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = 32'h00000000;
    next_supply_high = supply_high;
    // Write lands only at the edge where the master sees ready high
    if (psel && penable && pready && pwrite && paddr == `REG_CTRL) begin
      next_supply_high = pwdata[`CTRL_SUPPLY_HIGH];
    end
    if (psel && penable && !pready) begin
      next_pready = 1'b1;
      if (paddr == `REG_CTRL) begin
        next_prdata[`CTRL_SUPPLY_HIGH] = supply_high;
      end else if (paddr == `REG_STATUS) begin
        next_prdata[`ST_POWERED_DOWN] = powered_down;
        next_prdata[`ST_WAKING] = waking;
        next_prdata[`ST_LIVE] = live;
        next_prdata[`ST_TERM_LO +: 2] = term;
        next_prdata[`ST_GOOD_LO +: 8] = good_cnt;
        next_prdata[`ST_ABORT_LO +: 8] = abort_cnt;
      end else if (paddr >= `REG_OUT_BASE && paddr < `REG_IN_BASE
                   && paddr[1:0] == 2'h0) begin
        next_prdata[CW-1:0] = dac_codes[chan_of(paddr) * CW +: CW];
      end else if (paddr >= `REG_IN_BASE && paddr <= `REG_LAST
                   && paddr[1:0] == 2'h0) begin
        next_prdata[CW-1:0] = in_codes[chan_of(paddr) * CW +: CW];
      end else begin
        next_pslverr = 1'b1; // Unmapped address
      end
    end
  end

  // APB registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      supply_high <= `CTRL_RESET;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
      supply_high <= next_supply_high;
    end
  end

endmodule // quad_dac_powerdown_control

// file: dac_pd_props.sv
`timescale 1ns/10ps
module dac_pd_props #(
  parameter int WAKE_W = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Link and analog control
  input wire logic frame_sel_n,
  input wire logic [47:0] dac_codes,
  input wire logic linear_enable,
  input wire logic output_drive,
  input wire logic term_hiz,
  input wire logic term_2k5,
  input wire logic term_100k
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  reset_state_a: assert property ($rose(presetn) |-> dac_codes == 48'h0 && linear_enable && output_drive)
    else $error("outputs not at zero after reset");
  pd_shut_a: assert property (!linear_enable |-> !output_drive && $onehot({term_hiz, term_2k5, term_100k}))
    else $error("power-down state inconsistent");
  live_noterm_a: assert property (linear_enable |-> !(term_hiz || term_2k5 || term_100k))
    else $error("termination active while running");
  code_keep_a: assert property ($fell(linear_enable) |-> $stable(dac_codes))
    else $error("codes changed on power-down");
  wake_bound_a: assert property ($rose(linear_enable) |-> !output_drive ##[1:9] output_drive)
    else $error("wake-up too slow");
  quiet_link_a: assert property (frame_sel_n [*8] |=> $stable(dac_codes) && $stable(linear_enable))
    else $error("outputs moved without a frame");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("answer not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
endmodule // dac_pd_props

bind quad_dac_powerdown_control dac_pd_props #(.WAKE_W(WAKE_W)) u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .frame_sel_n(frame_sel_n), .dac_codes(dac_codes),
  .linear_enable(linear_enable), .output_drive(output_drive), .term_hiz(term_hiz),
  .term_2k5(term_2k5), .term_100k(term_100k));

// file: dac_host_model.sv
`timescale 1ns/10ps
module dac_host_model (
  // Clock
  input wire logic pclk,
  // Link pins
  output logic frame_sel_n,
  output logic shift_clk,
  output logic serial_data
);
  // Idle with clock stopped and data low, which keeps input current down
  initial begin
    frame_sel_n = 1'b1;
    shift_clk = 1'b0;
    serial_data = 1'b0;
  end

  // Half of an 800 ns link period
  task automatic half();
    repeat (4) @(posedge pclk);
  endtask

  // Sends n falling edges of w, MSB first; under 16 edges aborts the frame
  task automatic send(input logic [15:0] w, input int n);
    frame_sel_n <= 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      shift_clk <= 1'b1;
      serial_data <= (i < 16) ? w[15 - i] : 1'b1;
      half();
      shift_clk <= 1'b0;
      half();
    end
    frame_sel_n <= 1'b1;
    serial_data <= 1'b0;
    half();
  endtask
endmodule // dac_host_model

// file: quad_dac_powerdown_control_tb.sv
`timescale 1ns/10ps
module quad_dac_powerdown_control_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic frame_sel_n, shift_clk, serial_data;
  logic linear_enable, output_drive, term_hiz, term_2k5, term_100k;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [47:0] dac_codes;
  logic [2:0] tv [4] = '{3'b100, 3'b010, 3'b001, 3'b100};
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  quad_dac_powerdown_control #(.WAKE_W(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_sel_n(frame_sel_n), .shift_clk(shift_clk),
    .serial_data(serial_data), .dac_codes(dac_codes), .linear_enable(linear_enable),
    .output_drive(output_drive), .term_hiz(term_hiz), .term_2k5(term_2k5),
    .term_100k(term_100k));
  dac_host_model host (.pclk(pclk), .frame_sel_n(frame_sel_n), .shift_clk(shift_clk),
    .serial_data(serial_data));

  // Compare and count
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One APB transfer; the idle cycle after it keeps strobes from colliding
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    chk("codes", dac_codes, 48'h0);
    chk("modes", 48'({linear_enable, output_drive, term_hiz, term_2k5, term_100k}), 48'h18);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk("live", 48'(rd[2]), 48'h0);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", 48'(rd), 48'h1);
    apb(1'b0, 12'h028, 32'h0);
    chk("unmapped", 48'({er, rd}), 48'h1_0000_0000);
    host.send(16'h5123, 16);
    chk("write b", dac_codes, 48'h000_000_123_000);
    apb(1'b0, 12'h00C, 32'h0);
    chk("output b", 48'(rd), 48'h123);
    host.send(16'h0ABC, 16);
    chk("no update", dac_codes, 48'h000_000_123_000);
    apb(1'b0, 12'h018, 32'h0);
    chk("input a", 48'(rd), 48'hABC);
    host.send(16'h25A5, 20);
    chk("write all", dac_codes, 48'h5A5_5A5_5A5_5A5);
    host.send(16'h3FFF, 8);
    chk("abort", 48'({linear_enable, dac_codes[11:0]}), 48'h15A5);
    apb(1'b0, 12'h004, 32'h0);
    chk("counts", 48'(rd[31:16]), 48'h0103);
    // Every termination, each followed by a wake that only loads an input register
    for (int i = 0; i < 4; i++) begin
      host.send({i[1:0], 2'b11, 12'h000}, 16);
      chk("pd", 48'({linear_enable, output_drive, term_hiz, term_2k5, term_100k}), 48'(tv[i]));
      chk("pd codes", dac_codes, 48'h5A5_5A5_5A5_5A5);
      apb(1'b0, 12'h004, 32'h0);
      chk("term", 48'(rd[5:4]), (i == 3) ? 48'h1 : 48'(i + 1));
      host.send(16'hC0F0, 16);
      chk("wake", 48'({linear_enable, term_hiz, term_2k5, term_100k}), 48'h8);
      chk("kept", dac_codes, 48'h5A5_5A5_5A5_5A5);
      repeat (10) @(posedge pclk);
      chk("drive", 48'(output_drive), 48'h1);
    end
    host.send(16'h3000, 16);
    host.send(16'h1111, 16);
    chk("wake load", dac_codes, 48'h0F0_5A5_5A5_111);
    stop_test();
  end

  // Watchdog against a hung handshake
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      stop_test();
    end
  end
endmodule // quad_dac_powerdown_control_tb
